// [core/tca_core.sv]
// timer core: 16-bit counter, period, overflow flag, prescaler and external clock
// assumes one 50 MHz clock, break signals from the system unit on the same clock
// Notes on behaviour
// - debug break halts counter, blocks captures
// - break clear allowed: cleared flags stay cleared
// - break without permission: flags untouched by accesses
// - divider code 111 selects external clock pin
// - pin forced input while used as clock
// - channels 0,2,4 alone support buffered output
// - flag set at period match, reset clears
// - clear flag by read-then-write-zero only
// - interrupt request when flag set and enabled
// - halt bit holds counter, reset sets it
// - halted counter suppresses channel captures
// - clear bit zeroes counter and prescaler
// - halt plus clear leaves counter stopped at zero
// - divider codes select bus clock divide 1..64
// - high byte read latches low byte
// - counter bytes read-only, zero after clear
// - counter restarts at zero after period match
// - period high write blocks flag until low
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "tca_regs.svh"

module tca_core (
	input wire logic ref_clk,
	input wire logic srst,
	input tca_pkg::tca_bus_t bus_i,
	output logic [7:0] rdata_q,
	input wire logic break_active,
	input wire logic break_flag_clear_allow,
	input wire logic external_count_clock_pin,
	input wire logic pin_direction_bit,
	input tca_pkg::tca_chan_cfg_t chan_cfg_i,
	output logic pin_oe_q,
	output logic irq_q,
	output logic ovf_pulse_q,
	output logic [15:0] count_q,
	output logic [5:0] capture_allow_q,
	output logic [5:0] buffered_ok_q
);
	import tca_pkg::*;

	// ----------------------------------------
	// registers and wires
	// ----------------------------------------
	logic ovf_q;
	logic irq_en_q;
	logic halt_q;
	logic [2:0] div_q;
	logic [15:0] cnt_q;
	logic [15:0] period_q;
	logic blk_q;
	logic [7:0] latch_q;
	logic latched_q;
	logic [`TCA_PRE_W-1:0] pre_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	tca_clr_state_t clr_q;
	logic wr_stat;
	logic rd_stat;
	logic clear_req;
	logic run;
	logic tick;
	logic ext_sel;
	logic ext_rise;
	logic [`TCA_PRE_W-1:0] pre_mask;
	logic [15:0] cnt_nxt;
	logic ovf_evt;
	logic flag_lock;
	logic ovf_clr;
	logic ovf_d;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign wr_stat = bus_i.wr && bus_i.addr == `TCA_OFS_STATUS_CONTROL;
	assign rd_stat = bus_i.rd && bus_i.addr == `TCA_OFS_STATUS_CONTROL;
	// clear is write-only, acts in the write cycle
	assign clear_req = wr_stat && bus_i.wdata[`TCA_BIT_CLEAR];
	// break without permission freezes all flag traffic
	assign flag_lock = break_active && !break_flag_clear_allow;
	assign run = !halt_q && !break_active;
	assign ext_sel = div_q == `TCA_DIV_EXT;

	// ----------------------------------------
	// external clock pin
	// ----------------------------------------
	// edges faster than half our clock would be missed
	// by this sampler, hence the 4 MHz limit on the source
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= external_count_clock_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign ext_rise = ext_s2_q && !ext_s3_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_oe_q <= 1'b0;
		end else begin
			pin_oe_q <= pin_direction_bit && !ext_sel;
		end
	end

	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	always_comb begin
		case (div_q)
			3'h0: pre_mask = 6'h00;
			3'h1: pre_mask = 6'h01;
			3'h2: pre_mask = 6'h03;
			3'h3: pre_mask = 6'h07;
			3'h4: pre_mask = 6'h0f;
			3'h5: pre_mask = 6'h1f;
			3'h6: pre_mask = 6'h3f;
			default: pre_mask = 6'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst || clear_req) begin
			pre_q <= '0;
		end else if (run) begin
			pre_q <= pre_q + 6'h01;
		end
	end

	assign tick = run && (ext_sel ? ext_rise : (pre_q & pre_mask) == pre_mask);

	// ----------------------------------------
	// counter
	// ----------------------------------------
	assign cnt_nxt = (cnt_q == period_q) ? 16'h0000 : cnt_q + 16'h0001;
	assign ovf_evt = tick && cnt_nxt == period_q && !blk_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_q <= `TCA_RST_COUNT;
		end else if (clear_req) begin
			cnt_q <= 16'h0000;
		end else if (tick) begin
			cnt_q <= cnt_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			count_q <= `TCA_RST_COUNT;
			ovf_pulse_q <= 1'b0;
		end else begin
			count_q <= clear_req ? 16'h0000 : (tick ? cnt_nxt : cnt_q);
			ovf_pulse_q <= ovf_evt;
		end
	end

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_en_q <= 1'b0;
			halt_q <= `TCA_RST_HALT;
			div_q <= `TCA_RST_DIV;
		end else if (wr_stat) begin
			irq_en_q <= bus_i.wdata[`TCA_BIT_IRQ_EN];
			halt_q <= bus_i.wdata[`TCA_BIT_HALT];
			div_q <= bus_i.wdata[`TCA_DIV_MSB:`TCA_DIV_LSB];
		end
	end

	// ----------------------------------------
	// period
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			period_q <= `TCA_RST_PERIOD;
			blk_q <= 1'b0;
		end else if (bus_i.wr && bus_i.addr == `TCA_OFS_PERIOD_HIGH) begin
			period_q[15:8] <= bus_i.wdata;
			blk_q <= 1'b1;
		end else if (bus_i.wr && bus_i.addr == `TCA_OFS_PERIOD_LOW) begin
			period_q[7:0] <= bus_i.wdata;
			blk_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// overflow flag
	// ----------------------------------------
	// arming survives a locked break, so the second step
	// after the break still completes the clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			clr_q <= TCA_CLR_IDLE;
		end else begin
			case (clr_q)
				TCA_CLR_IDLE: begin
					if (rd_stat && ovf_q && !flag_lock && !ovf_evt) begin
						clr_q <= TCA_CLR_ARMED;
					end
				end
				TCA_CLR_ARMED: begin
					if (ovf_evt) begin
						clr_q <= TCA_CLR_IDLE;
					end else if (wr_stat && !flag_lock) begin
						clr_q <= TCA_CLR_IDLE;
					end
				end
				default: clr_q <= TCA_CLR_IDLE;
			endcase
		end
	end

	assign ovf_clr = clr_q == TCA_CLR_ARMED && wr_stat && !flag_lock
		&& !bus_i.wdata[`TCA_BIT_OVF];
	// a new overflow beats a clear in the same cycle
	assign ovf_d = ovf_evt || (ovf_q && !ovf_clr);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= ovf_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ovf_q && irq_en_q;
		end
	end

	// ----------------------------------------
	// channel gating
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			capture_allow_q <= 6'h00;
			buffered_ok_q <= 6'h00;
		end else begin
			capture_allow_q <= chan_cfg_i.capture_mode & {6{run}};
			buffered_ok_q <= chan_cfg_i.buffered_req & `TCA_BUF_CH_MASK;
		end
	end

	// ----------------------------------------
	// counter readback latch
	// ----------------------------------------
	// a latch left set in break keeps the old low byte
	always_ff @(posedge ref_clk) begin
		if (srst || clear_req) begin
			latch_q <= 8'h00;
			latched_q <= 1'b0;
		end else if (bus_i.rd && bus_i.addr == `TCA_OFS_COUNT_HIGH && !latched_q) begin
			latch_q <= cnt_q[7:0];
			latched_q <= 1'b1;
		end else if (bus_i.rd && bus_i.addr == `TCA_OFS_COUNT_LOW) begin
			latched_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else if (bus_i.rd) begin
			case (bus_i.addr)
				`TCA_OFS_STATUS_CONTROL:
					rdata_q <= {ovf_q, irq_en_q, halt_q, 2'b00, div_q};
				`TCA_OFS_COUNT_HIGH: rdata_q <= cnt_q[15:8];
				`TCA_OFS_COUNT_LOW: rdata_q <= latched_q ? latch_q : cnt_q[7:0];
				`TCA_OFS_PERIOD_HIGH: rdata_q <= period_q[15:8];
				`TCA_OFS_PERIOD_LOW: rdata_q <= period_q[7:0];
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	sequence clr_arm_s;
		clr_q == TCA_CLR_ARMED;
	endsequence

	sequence clr_write_s;
		wr_stat && !bus_i.wdata[`TCA_BIT_OVF] && !flag_lock && !ovf_evt;
	endsequence

	brk_hold_a: assert property (break_active && !clear_req |=> $stable(cnt_q))
		else $error("counter moved during break");
	halt_hold_a: assert property (halt_q && !clear_req |=> $stable(cnt_q))
		else $error("counter moved while halted");
	cap_block_a: assert property (!run |=> capture_allow_q == 6'h00)
		else $error("capture allowed while stopped");
	ovf_set_a: assert property (ovf_evt |=> ovf_q && ovf_pulse_q)
		else $error("overflow flag not set");
	ovf_clear_a: assert property (clr_arm_s ##0 clr_write_s |=> !ovf_q)
		else $error("flag not cleared by second step");
	wr_one_a: assert property (!ovf_q && !ovf_evt |=> !ovf_q)
		else $error("flag set without overflow");
	lock_keep_a: assert property (flag_lock && ovf_q |=> ovf_q)
		else $error("flag changed in locked break");
	irq_req_a: assert property (ovf_q && irq_en_q |=> irq_q)
		else $error("interrupt request missing");
	clr_zero_a: assert property (clear_req |=> cnt_q == 16'h0000 && count_q == 16'h0000)
		else $error("clear did not zero counter");
	halt_clr_a: assert property (clear_req && bus_i.wdata[`TCA_BIT_HALT]
		|=> halt_q && cnt_q == 16'h0000 ##1 cnt_q == 16'h0000)
		else $error("halt with clear did not stop at zero");
	wrap_zero_a: assert property (tick && cnt_q == period_q && !clear_req |=> cnt_q == 16'h0000)
		else $error("counter did not restart");
	blk_flag_a: assert property (blk_q && !ovf_q |=> !ovf_q)
		else $error("flag set while period blocked");
	div_one_a: assert property (run && div_q == 3'h0 && !clear_req
		&& cnt_q != period_q |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("divide-by-one did not count");
	ext_only_a: assert property (ext_sel && !ext_rise && !clear_req |=> $stable(cnt_q))
		else $error("counter moved without pin edge");
	lat_keep_a: assert property (latched_q && !bus_i.rd && !clear_req |=> $stable(latch_q))
		else $error("latched low byte changed");
	pin_in_a: assert property (ext_sel |=> !pin_oe_q)
		else $error("clock pin driven");
	buf_chan_a: assert property (##1 (buffered_ok_q & 6'h2a) == 6'h00)
		else $error("odd channel buffered");
	pre_clear_a: assert property (clear_req |=> pre_q == 6'h00)
		else $error("clear did not zero prescaler");
	pre_hold_a: assert property (!run && !clear_req |=> $stable(pre_q))
		else $error("prescaler moved while stopped");
	reset_vals_a: assert property ($fell(srst) |-> halt_q && !ovf_q && !irq_en_q
		&& div_q == `TCA_RST_DIV && period_q == `TCA_RST_PERIOD && cnt_q == `TCA_RST_COUNT)
		else $error("wrong state after reset");
	irq_off_a: assert property (!irq_en_q |=> !irq_q)
		else $error("interrupt request while disabled");
	ext_count_a: assert property (ext_sel && ext_rise && run && !clear_req
		&& cnt_q != period_q |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("pin edge did not count");
	wr_one_keep_a: assert property (ovf_q && wr_stat && bus_i.wdata[`TCA_BIT_OVF]
		|=> ovf_q)
		else $error("writing one cleared the flag");
	lat_take_a: assert property (bus_i.rd && bus_i.addr == `TCA_OFS_COUNT_HIGH
		&& !latched_q |=> latched_q && latch_q == $past(cnt_q[7:0]))
		else $error("low byte not latched");
	pin_out_a: assert property (!ext_sel && pin_direction_bit |=> pin_oe_q)
		else $error("pin not driven as output");
	cap_pass_a: assert property (run
		|=> capture_allow_q == $past(chan_cfg_i.capture_mode))
		else $error("capture blocked while running");
	clr_reads_a: assert property (rd_stat |=> rdata_q[`TCA_BIT_CLEAR] == 1'b0)
		else $error("clear bit read back as one");
	cnt_ro_a: assert property (bus_i.wr && bus_i.addr == `TCA_OFS_COUNT_LOW && !tick
		|=> $stable(cnt_q))
		else $error("counter byte was writable");

endmodule

// [core/tca_pkg.sv]
// types shared by the timer core
// assumes tca_regs.svh sits beside it
package tca_pkg;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tca_bus_t;

	typedef struct packed {
		logic [5:0] capture_mode;
		logic [5:0] buffered_req;
	} tca_chan_cfg_t;

	typedef enum logic [1:0] {
		TCA_CLR_IDLE = 2'b01,
		TCA_CLR_ARMED = 2'b10
	} tca_clr_state_t;

endpackage

// [core/tca_regs.svh]
// register offsets, field positions, reset values and timing counts of the timer core
// assumes byte-wide registers on a plain port with a 3-bit address
`ifndef TCA_REGS_SVH
`define TCA_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define TCA_OFS_STATUS_CONTROL 3'h0
`define TCA_OFS_COUNT_HIGH 3'h1
`define TCA_OFS_COUNT_LOW 3'h2
`define TCA_OFS_PERIOD_HIGH 3'h3
`define TCA_OFS_PERIOD_LOW 3'h4

// ----------------------------------------
// status_control fields
// ----------------------------------------
`define TCA_BIT_OVF 7
`define TCA_BIT_IRQ_EN 6
`define TCA_BIT_HALT 5
`define TCA_BIT_CLEAR 4
`define TCA_DIV_MSB 2
`define TCA_DIV_LSB 0
`define TCA_DIV_EXT 3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define TCA_RST_COUNT 16'h0000
`define TCA_RST_PERIOD 16'hffff
`define TCA_RST_DIV 3'h0
`define TCA_RST_HALT 1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define TCA_CLK_MHZ 50
`define TCA_EXT_MAX_MHZ 4
// shortest external edge spacing, in reference cycles
`define TCA_EXT_MIN_CYC (`TCA_CLK_MHZ / `TCA_EXT_MAX_MHZ)
`define TCA_PRE_W 6
`define TCA_BUF_CH_MASK 6'h15

`endif

// [sim/tb.sv]
// directed testbench of the timer core over its register port
// assumes tca_core and tca_clk_src are compiled before it
`timescale 1ns/100ps
module tb;
	import tca_pkg::*;
	logic ref_clk, srst, brk, allow, dir, ext_run, ext_pin, pin_oe, irq, pulse;
	tca_bus_t bus;
	tca_chan_cfg_t cfg;
	logic [7:0] rd, v, vh;
	logic [15:0] cnt, c0;
	logic [5:0] cap, buf_ok;
	int miscompares, samples_checked, n, c;
	tca_core dut_u (.ref_clk(ref_clk), .srst(srst), .bus_i(bus), .rdata_q(rd),
		.break_active(brk), .break_flag_clear_allow(allow),
		.external_count_clock_pin(ext_pin), .pin_direction_bit(dir), .chan_cfg_i(cfg),
		.pin_oe_q(pin_oe), .irq_q(irq), .ovf_pulse_q(pulse), .count_q(cnt),
		.capture_allow_q(cap), .buffered_ok_q(buf_ok));
	tca_clk_src src_u (.run(ext_run), .pin(ext_pin));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// checks and bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// range check: edge alignment of long runs is left open by the hand-over
	task automatic rng(input string nm, input int lo, input int hi, input logic [15:0] g);
		samples_checked++;
		if ($isunknown(g) || g < lo || g > hi) begin
			miscompares++;
			$display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask
	task automatic rdr(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1;
		d = rd;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		rdr(a, d);
		chk($sformatf("reg%0d", a), {8'h00, e}, {8'h00, d});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_ovf;
		n = 0;
		while (pulse !== 1'b1 && n < 50) begin
			cyc(1);
			n++;
		end
		chk("ovf pulse", 16'h0001, {15'h0000, pulse});
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		results();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		bus = '0;
		cfg = '{6'h3f, 6'h3f};
		{brk, allow, dir, ext_run} = 4'h0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		rdc(3'h0, 8'h20);
		wr(3'h1, 8'h55);
		rdc(3'h1, 8'h00);
		rdc(3'h2, 8'h00);
		rdc(3'h3, 8'hff);
		rdc(3'h4, 8'hff);
		rdc(3'h5, 8'h00);
		chk("capture", 16'h0000, {10'h000, cap});
		chk("buffered", 16'h0015, {10'h000, buf_ok});
		wr(3'h3, 8'h00);
		wr(3'h4, 8'h03);
		wr(3'h0, 8'h00);
		wait_ovf();
		chk("capture", 16'h003f, {10'h000, cap});
		repeat (12) begin
			cyc(1);
			rng("wrap", 0, 3, cnt);
		end
		wr(3'h0, 8'ha0);
		rdc(3'h0, 8'ha0);
		wr(3'h0, 8'h20);
		rdc(3'h0, 8'h20);
		wr(3'h0, 8'h00);
		wait_ovf();
		rdc(3'h0, 8'h80);
		wait_ovf();
		wr(3'h0, 8'h20);
		rdc(3'h0, 8'ha0);
		wr(3'h0, 8'h60);
		rdc(3'h0, 8'h60);
		wr(3'h0, 8'h40);
		wait_ovf();
		cyc(2);
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(3'h0, 8'h70);
		rdc(3'h0, 8'he0);
		rdc(3'h1, 8'h00);
		rdc(3'h2, 8'h00);
		chk("count", 16'h0000, cnt);
		rdr(3'h0, v);
		wr(3'h0, 8'h20);
		cyc(2);
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(3'h3, 8'h00);
		wr(3'h0, 8'h00);
		n = 0;
		repeat (30) begin
			cyc(1);
			if (pulse === 1'b1) begin
				n++;
			end
		end
		chk("blocked ovf", 16'h0000, n[15:0]);
		rdc(3'h0, 8'h00);
		wr(3'h4, 8'h03);
		wait_ovf();
		rdr(3'h0, v);
		@(posedge ref_clk);
		brk <= 1'b1;
		cyc(3);
		chk("capture", 16'h0000, {10'h000, cap});
		c0 = cnt;
		cyc(10);
		chk("count held", c0, cnt);
		rdc(3'h1, c0[15:8]);
		rdc(3'h2, c0[7:0]);
		rdr(3'h0, v);
		wr(3'h0, 8'h00);
		rdc(3'h0, 8'h80);
		@(posedge ref_clk);
		allow <= 1'b1;
		rdr(3'h0, v);
		wr(3'h0, 8'h20);
		rdc(3'h0, 8'h20);
		@(posedge ref_clk);
		brk <= 1'b0;
		allow <= 1'b0;
		cyc(5);
		rdc(3'h0, 8'h20);
		wr(3'h0, 8'h30);
		wr(3'h3, 8'hff);
		wr(3'h4, 8'hff);
		for (c = 0; c < 7; c++) begin
			wr(3'h0, 8'h30);
			wr(3'h0, c[7:0]);
			cyc(254);
			wr(3'h0, 8'h20 | c[7:0]);
			rdr(3'h1, vh);
			rdr(3'h2, v);
			rng("divided", (256 >> c) - 2, (256 >> c) + 1, {vh, v});
		end
		wr(3'h0, 8'h30);
		wr(3'h0, 8'h00);
		rdr(3'h1, v);
		cyc(20);
		rdr(3'h1, v);
		wr(3'h0, 8'h20);
		rdr(3'h2, v);
		rng("latched low", 0, 6, {8'h00, v});
		rdr(3'h2, v);
		rng("live low", 22, 34, {8'h00, v});
		@(posedge ref_clk);
		dir <= 1'b1;
		cyc(3);
		chk("pin oe", 16'h0001, {15'h0000, pin_oe});
		wr(3'h0, 8'h37);
		wr(3'h0, 8'h07);
		cyc(3);
		chk("pin oe", 16'h0000, {15'h0000, pin_oe});
		ext_run <= 1'b1;
		cyc(125);
		ext_run <= 1'b0;
		cyc(10);
		wr(3'h0, 8'h27);
		rdr(3'h2, v);
		rng("external", 9, 10, {8'h00, v});
		results();
	end
endmodule

// [sim/tca_clk_src.sv]
// far-side model: external count clock driving the shared pin
// assumes a 1 ns time unit; the pin stands low while no run is asked
`timescale 1ns/100ps
module tca_clk_src (
	input wire logic run,
	output logic pin
);
	// 125 ns half period gives 4 MHz, below half of the 50 MHz bus rate
	always begin
		if (run === 1'b1) begin
			#125;
			pin = ~pin;
		end else begin
			pin = 1'b0;
			#5;
		end
	end
endmodule
